// file: core/qeq_smbus_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - ack address match and register address
// - shift out addressed register after ack
// - registers 0..2 read-only status
// - regs 3,4 disable bit and boost
// - register 5 rise detect levels
// - register 6 fall detect levels
// - register 7 bit 0 selects register enable bits over enable pins
// - register 8 bits 3:2 output swing
// - enable from pins or register bits
// - respond only while chip select high
// - slave address 1010110
// - boost from register or boost pins
module qeq_smbus_regs #(
  parameter logic [3:0] REVISION = 4'h1 // arbitrary value
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire qeq_pkg::qeq_bus_in_s i_bus,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [3:0] i_channel_signal_present,
  input wire logic [3:0] i_channel_enable_pins,
  input wire logic i_boost_source_pin,
  input wire logic [2:0] i_boost_level_pins,
  output qeq_pkg::qeq_cfg_s o_cfg
);
  import qeq_pkg::*;

  typedef enum logic [2:0] {st_idle, st_addr, st_reg, st_data, st_send, st_ack, st_rack, st_skip} qeq_state_e;

  // two-stage synchronisers; stage one read only by stage two
  qeq_bus_in_s sync1, sync2;
  logic [3:0] sd1, sd2, en1, en2;
  logic fs1, fs2;
  logic [2:0] bp1, bp2;
  logic scl_d, sda_d;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // select idles low, so no phantom selection right after reset
      sync1 <= '{scl: 1'b1, sda: 1'b1, select: 1'b0};
      sync2 <= '{scl: 1'b1, sda: 1'b1, select: 1'b0};
      sd1 <= '0;
      sd2 <= '0;
      en1 <= '0;
      en2 <= '0;
      fs1 <= 1'b1;
      fs2 <= 1'b1;
      bp1 <= 3'h4;
      bp2 <= 3'h4;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync1 <= i_bus;
      sync2 <= sync1;
      sd1 <= i_channel_signal_present;
      sd2 <= sd1;
      en1 <= i_channel_enable_pins;
      en2 <= en1;
      fs1 <= i_boost_source_pin;
      fs2 <= fs1;
      bp1 <= i_boost_level_pins;
      bp2 <= bp1;
      scl_d <= sync2.scl;
      sda_d <= sync2.sda;
    end
  end

  wire scl_rise = sync2.scl && !scl_d;
  wire scl_fall = !sync2.scl && scl_d;
  wire start_cond = scl_d && sync2.scl && sda_d && !sync2.sda;
  wire stop_cond = scl_d && sync2.scl && !sda_d && sync2.sda;

  logic [7:0] r_ch01, r_ch23, r_on, r_off, r_ctl, r_swing;
  qeq_state_e state;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [7:0] reg_ptr;
  logic is_read, have_ptr, wr_pulse, ack_ok;
  qeq_state_e after_ack;

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    case (a)
      qeq_reg_detect_status: read_reg = {REVISION, sd2};
      qeq_reg_ch01_state: read_reg = r_ch01;
      qeq_reg_ch23_state: read_reg = r_ch23;
      qeq_reg_ch01_on_boost: read_reg = r_ch01;
      qeq_reg_ch23_on_boost: read_reg = r_ch23;
      qeq_reg_detect_on: read_reg = r_on;
      qeq_reg_detect_off: read_reg = r_off;
      qeq_reg_port_control: read_reg = r_ctl;
      qeq_reg_output_swing: read_reg = r_swing;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // protocol engine; all activity gated by chip select
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= st_idle;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      reg_ptr <= 8'h00;
      is_read <= 1'b0;
      have_ptr <= 1'b0;
      wr_pulse <= 1'b0;
      ack_ok <= 1'b0;
      after_ack <= st_idle;
    end else begin
      wr_pulse <= 1'b0;
      if (!sync2.select) begin
        state <= st_idle;
      end else if (start_cond) begin
        state <= st_addr;
        bitcnt <= 4'h0;
        have_ptr <= 1'b0;
      end else if (stop_cond) begin
        state <= st_idle;
      end else begin
        case (state)
          st_addr, st_reg, st_data: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sync2.sda};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              ack_ok <= 1'b1;
              if (state == st_addr) begin
                if (shreg[7:1] == qeq_slave_addr) begin
                  is_read <= shreg[0];
                  state <= st_ack;
                  after_ack <= shreg[0] ? st_send : st_reg;
                end else begin
                  state <= st_skip;
                end
              end else if (state == st_reg) begin
                reg_ptr <= shreg;
                have_ptr <= 1'b1;
                state <= st_ack;
                after_ack <= st_data;
              end else begin
                wr_pulse <= 1'b1;
                state <= st_ack;
                after_ack <= st_data;
              end
            end
          end
          st_ack: begin
            if (scl_fall) begin
              ack_ok <= 1'b0;
              state <= after_ack;
              if (after_ack == st_send) begin
                shreg <= read_reg(reg_ptr);
                bitcnt <= 4'h0;
              end
            end
          end
          st_send: begin
            if (scl_fall) begin
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == 4'h7) begin
                state <= st_rack;
              end
            end
          end
          st_rack: begin
            // host ack asks for the next byte; nack ends the read
            if (scl_rise) begin
              if (sync2.sda) begin
                state <= st_skip;
              end else begin
                reg_ptr <= reg_ptr + 8'h01;
              end
            end
            if (scl_fall && !sync2.sda) begin
              state <= st_send;
              shreg <= read_reg(reg_ptr);
              bitcnt <= 4'h0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // data on sda stays until scl falls, ack/data driven low only
  always_comb begin
    o_sda_oe = 1'b0;
    if (state == st_ack) begin
      o_sda_oe = ack_ok;
    end else if (state == st_send) begin
      o_sda_oe = !shreg[7];
    end
  end
  assign o_sda_out = 1'b0;

  // write path; status and unknown offsets drop the write
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_ch01 <= qeq_rst_on_boost;
      r_ch23 <= qeq_rst_on_boost;
      r_on <= qeq_rst_detect_on;
      r_off <= qeq_rst_detect_off;
      r_ctl <= qeq_rst_port_control;
      r_swing <= qeq_rst_output_swing;
    end else if (wr_pulse && have_ptr) begin
      case (reg_ptr)
        qeq_reg_ch01_on_boost: r_ch01 <= shreg;
        qeq_reg_ch23_on_boost: r_ch23 <= shreg;
        qeq_reg_detect_on: r_on <= shreg;
        qeq_reg_detect_off: r_off <= shreg;
        qeq_reg_port_control: r_ctl <= shreg & qeq_mask_port_control;
        qeq_reg_output_swing: r_swing <= (shreg & qeq_mask_output_swing) | (r_swing & ~qeq_mask_output_swing);
        default: begin
        end
      endcase
    end
  end

  // reserved swing bits hold reset pattern as printed default
  logic [15:0] ctl_bits;
  assign ctl_bits = {r_ch23, r_ch01};
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cfg <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        o_cfg.active[c] <= r_ctl[0] ? !ctl_bits[4*c+qeq_off_bit_pos] : en2[c];
        o_cfg.boost[3*c +: 3] <= fs2 ? bp2 : ctl_bits[4*c +: 3];
      end
      o_cfg.rise_level <= r_on;
      o_cfg.fall_level <= r_off;
      o_cfg.swing <= r_swing[qeq_swing_lsb +: 2];
    end
  end
endmodule : qeq_smbus_regs

// file: pkg/qeq_pkg.sv
package qeq_pkg;
  localparam logic [6:0] qeq_slave_addr = 7'h56;
  localparam logic [7:0] qeq_reg_detect_status = 8'h00;
  localparam logic [7:0] qeq_reg_ch01_state = 8'h01;
  localparam logic [7:0] qeq_reg_ch23_state = 8'h02;
  localparam logic [7:0] qeq_reg_ch01_on_boost = 8'h03;
  localparam logic [7:0] qeq_reg_ch23_on_boost = 8'h04;
  localparam logic [7:0] qeq_reg_detect_on = 8'h05;
  localparam logic [7:0] qeq_reg_detect_off = 8'h06;
  localparam logic [7:0] qeq_reg_port_control = 8'h07;
  localparam logic [7:0] qeq_reg_output_swing = 8'h08;
  localparam logic [7:0] qeq_rst_on_boost = 8'h44;
  localparam logic [7:0] qeq_rst_detect_on = 8'h00;
  localparam logic [7:0] qeq_rst_detect_off = 8'h00;
  localparam logic [7:0] qeq_rst_port_control = 8'h00;
  localparam logic [7:0] qeq_rst_output_swing = 8'h78;
  localparam logic [7:0] qeq_mask_port_control = 8'h01;
  localparam logic [7:0] qeq_mask_output_swing = 8'h0c;
  localparam int qeq_swing_lsb = 2;
  localparam int qeq_off_bit_pos = 3;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       select;
  } qeq_bus_in_s;

  typedef struct packed {
    logic [3:0] active;
    logic [11:0] boost;
    logic [7:0] rise_level;
    logic [7:0] fall_level;
    logic [1:0] swing;
  } qeq_cfg_s;
endpackage : qeq_pkg

// file: sim/qeq_host_model.sv
`timescale 1ns/100ps
module qeq_host_model (
  output logic o_scl,
  output logic o_sel,
  output logic o_sda_oe,
  input wire logic i_sda
);
  logic [7:0] res;
  bit en = 1;
  event got;
  initial begin
    o_scl = 1;
    o_sel = 0;
    o_sda_oe = 0;
  end
  // one bit of 125 ns; clock stands high between frames
  task bt(input logic b, output logic r);
    #31 o_sda_oe = !b;
    #31 o_scl = 1;
    #32 r = i_sda;
    #31 o_scl = 0;
  endtask : bt
  // select rises a while after the last stop's deselect, never in the same step
  task start;
    #100 o_sel = en;
    #100 o_sda_oe = 1;
    #50 o_scl = 0;
  endtask : start
  task rstart;
    #31 o_sda_oe = 0;
    #31 o_scl = 1;
    #50 o_sda_oe = 1;
    #50 o_scl = 0;
  endtask : rstart
  task stop;
    #31 o_sda_oe = 1;
    #31 o_scl = 1;
    #50 o_sda_oe = 0;
    #50 o_sel = 0;
  endtask : stop
  task wb(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    res = {7'h00, r};
    ->got;
  endtask : wb
  task rb;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, r);
      res[i] = r;
    end
    bt(1'b1, r);
    ->got;
  endtask : rb
endmodule : qeq_host_model

// file: sim/qeq_smbus_regs_sva.sv
`timescale 1ns/100ps
module qeq_smbus_regs_sva
  import qeq_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire qeq_pkg::qeq_bus_in_s i_bus,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_boost_source_pin,
  input wire logic [2:0] i_boost_level_pins,
  input wire qeq_pkg::qeq_cfg_s o_cfg
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  property p_sda_zero; o_sda_out == 1'b0; endproperty
  a_sda_zero: assert property (p_sda_zero) else $error("sda value high");
  property p_quiet_deselect; !i_bus.select [*5] |-> !o_sda_oe; endproperty
  a_quiet_deselect: assert property (p_quiet_deselect) else $error("drive while deselected");
  property p_drive_selected; o_sda_oe |-> $past(i_bus.select, 2); endproperty
  a_drive_selected: assert property (p_drive_selected) else $error("drive without select");
  property p_rise_scl_low; $rose(o_sda_oe) |-> !i_bus.scl; endproperty
  a_rise_scl_low: assert property (p_rise_scl_low) else $error("drive starts in clock high");
  property p_fall_scl_low; $fell(o_sda_oe) |-> !i_bus.scl; endproperty
  a_fall_scl_low: assert property (p_fall_scl_low) else $error("release in clock high");
  // data must not move while the bus clock is high, or it reads as start/stop
  property p_hold_high; $rose(i_bus.scl) |-> $stable(o_sda_oe) [*4]; endproperty
  a_hold_high: assert property (p_hold_high) else $error("sda moved in clock high");
  property p_bit_stands; $rose(o_sda_oe) |=> o_sda_oe [*8]; endproperty
  a_bit_stands: assert property (p_bit_stands) else $error("low bit too short");
  property p_pin_boost;
    (i_boost_source_pin && $stable(i_boost_level_pins)) [*6] |-> o_cfg.boost == {4{i_boost_level_pins}};
  endproperty
  a_pin_boost: assert property (p_pin_boost) else $error("boost not from pins");
endmodule : qeq_smbus_regs_sva
bind qeq_smbus_regs qeq_smbus_regs_sva qeq_smbus_regs_sva_inst (.i_clock, .i_arst_n, .i_bus, .o_sda_out,
  .o_sda_oe, .i_boost_source_pin, .i_boost_level_pins, .o_cfg);

// file: sim/qeq_smbus_regs_tb_top.sv
`timescale 1ns/100ps
module qeq_smbus_regs_tb_top;
  import qeq_pkg::*;
  localparam logic [3:0] REV = 4'h5; // arbitrary value
  logic i_clock = 0, i_arst_n = 0, scl, sel, h_oe, o_sda_out, o_sda_oe, src = 0;
  logic [3:0] sig = 0, pins = 0;
  logic [2:0] bl = 0;
  logic [7:0] q[$], d, e;
  logic [7:0] rv[6] = '{8'h44, 8'h44, 8'h00, 8'h00, 8'h00, 8'h78};
  qeq_cfg_s cfg;
  int bad_count = 0, checks = 0, cyc = 0, seed = 32'h4d41;
  wire sda = !(h_oe || (o_sda_oe && !o_sda_out));
  always #5 i_clock = !i_clock;
  qeq_host_model qeq_host_model_inst (.o_scl(scl), .o_sel(sel), .o_sda_oe(h_oe), .i_sda(sda));
  qeq_smbus_regs #(.REVISION(REV)) qeq_smbus_regs_inst (.i_clock, .i_arst_n, .i_bus({scl, sda, sel}),
    .o_sda_out, .o_sda_oe, .i_channel_signal_present(sig), .i_channel_enable_pins(pins),
    .i_boost_source_pin(src), .i_boost_level_pins(bl), .o_cfg(cfg));
  task chk(input logic [11:0] s, input logic [11:0] x);
    checks++;
    if (s !== x) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, x);
    end
  endtask : chk
  task end_of_test;
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  always @(qeq_host_model_inst.got) chk(qeq_host_model_inst.res, q.pop_front());
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      end_of_test();
    end
  end
  task acc(input logic [7:0] a, input logic [7:0] dd, input bit rd, input logic [7:0] x);
    q.push_back(8'h00);
    q.push_back(8'h00);
    q.push_back(8'h00);
    if (rd) q.push_back(x);
    qeq_host_model_inst.start();
    qeq_host_model_inst.wb({qeq_slave_addr, 1'b0});
    qeq_host_model_inst.wb(a);
    if (rd) begin
      qeq_host_model_inst.rstart();
      qeq_host_model_inst.wb({qeq_slave_addr, 1'b1});
      qeq_host_model_inst.rb();
    end else qeq_host_model_inst.wb(dd);
    qeq_host_model_inst.stop();
  endtask : acc
  // refused address: a single nack is all that may come back
  task nak(input logic [6:0] a);
    q.push_back(8'h01);
    qeq_host_model_inst.start();
    qeq_host_model_inst.wb({a, 1'b0});
    qeq_host_model_inst.stop();
  endtask : nak
  initial begin
    repeat (16) @(posedge i_clock);
    i_arst_n <= 1;
    repeat (4) @(posedge i_clock);
    foreach (rv[i]) acc(i + 3, 0, 1, rv[i]);
    chk(cfg.swing, 2'b10);
    chk(cfg.rise_level, qeq_rst_detect_on);
    chk(cfg.fall_level, qeq_rst_detect_off);
    chk(cfg.boost, {4{3'b100}});
    for (int i = 3; i < 9; i++) begin
      d = $random(seed);
      acc(i, d, 0, 0);
      acc(i, 0, 1, i == 7 ? d & 8'h01 : i == 8 ? (d & 8'h0c) | 8'h70 : d);
      if (i == 5) chk(cfg.rise_level, d);
      if (i == 6) chk(cfg.fall_level, d);
    end
    chk(cfg.swing, d[3:2]);
    d = $random(seed);
    e = $random(seed);
    @(posedge i_clock);
    sig <= $random(seed);
    pins <= $random(seed);
    acc(3, d, 0, 0);
    acc(4, e, 0, 0);
    acc(1, ~d, 0, 0);
    acc(0, 8'hff, 0, 0);
    acc(1, 0, 1, d);
    acc(2, 0, 1, e);
    acc(0, 0, 1, {REV, sig});
    acc(8'h20, 0, 1, 0);
    nak(7'h57);
    qeq_host_model_inst.en = 0;
    nak(qeq_slave_addr);
    qeq_host_model_inst.en = 1;
    acc(7, 0, 0, 0);
    chk(cfg.active, pins);
    chk(cfg.boost, {e[6:4], e[2:0], d[6:4], d[2:0]});
    acc(7, 1, 0, 0);
    chk(cfg.active, {~{e[7], e[3], d[7], d[3]}});
    @(posedge i_clock);
    src <= 1;
    bl <= $random(seed);
    repeat (8) @(posedge i_clock);
    chk(cfg.boost, {4{bl}});
    end_of_test();
  end
endmodule : qeq_smbus_regs_tb_top
